// File: flash_front_end.v
`timescale 1ns/1ps
`include "flash_fe_consts.vh"
module flash_front_end (
   // clock and reset
   input  wire        ref_clk_in,
   input  wire        srst_in,
   // serial link pins
   input  wire        sel_n_in,
   input  wire        sclk_in,
   input  wire [3:0]  sio_in,
   output reg  [3:0]  sio_out,
   output reg  [3:0]  sio_oe_n_out,
   // array side request stream
   output reg         op_valid_out,
   input  wire        op_ready_in,
   output reg  [7:0]  op_code_out,
   output reg  [23:0] op_addr_out,
   output reg  [11:0] op_sector_out,
   output reg  [8:0]  op_half_block_out,
   output reg  [7:0]  op_block_out,
   // array side read data
   input  wire [7:0]  rd_data_in,
   // state
   output reg         quad_mode_out,
   output reg         write_enable_latch_out,
   output reg         busy_out,
   input  wire        quad_enable_bit_in
);
   localparam ST_IDLE = 3'd0, ST_OPC = 3'd1, ST_ADDR = 3'd2, ST_DUMMY = 3'd3;
   localparam ST_DATA = 3'd4, ST_WDATA = 3'd5, ST_STBY = 3'd6;
   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   reg [1:0] sel_s_r, clk_s_r;
   reg [3:0] sio_s1_r, sio_s2_r;
   reg       sel_d_r, clk_d_r;
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         sel_s_r  <= 2'b11;
         clk_s_r  <= 2'b00;
         sio_s1_r <= 4'h0;
         sio_s2_r <= 4'h0;
         sel_d_r  <= 1'b1;
         clk_d_r  <= 1'b0;
      end else begin
         sel_s_r  <= {sel_s_r[0], sel_n_in};
         clk_s_r  <= {clk_s_r[0], sclk_in};
         sio_s1_r <= sio_in;
         sio_s2_r <= sio_s1_r;
         sel_d_r  <= sel_s_r[1];
         clk_d_r  <= clk_s_r[1];
      end
   end
   wire sel_fall = sel_d_r & ~sel_s_r[1];
   wire sel_rise = ~sel_d_r & sel_s_r[1];
   // edges only count while selected, so a mode 3 idle-high clock
   // dropping after select fall is a harmless shift edge
   wire clk_rise = ~sel_s_r[1] & ~clk_d_r & clk_s_r[1];
   wire clk_fall = ~sel_s_r[1] & clk_d_r & ~clk_s_r[1];
   // -------------------------------------------------------------
   // command decode helpers
   // -------------------------------------------------------------
   reg [7:0]  opc_r;
   function is_write_type;
      input [7:0] op;
      begin
         is_write_type = (op == `OP_PAGE_PROG) || (op == `OP_SECTOR_ERASE) ||
                         (op == `OP_BLK32_ERASE) || (op == `OP_BLK64_ERASE) ||
                         (op == `OP_CHIP_ERASE) || (op == `OP_CHIP_ERASE2) ||
                         (op == `OP_STATUS_WR);
      end
   endfunction
   function needs_addr;
      input [7:0] op;
      begin
         needs_addr = (op == `OP_READ) || (op == `OP_FAST_READ) || (op == `OP_PAGE_PROG) ||
                      (op == `OP_SECTOR_ERASE) || (op == `OP_BLK32_ERASE) || (op == `OP_BLK64_ERASE);
      end
   endfunction
   function is_known;
      input [7:0] op;
      input       quad;
      begin
         is_known = needs_addr(op) || is_write_type(op) || (op == `OP_WRITE_EN) ||
                    (op == `OP_WRITE_DIS) || (op == `OP_STATUS_RD) ||
                    (op == `OP_QUAD_ENTER && !quad) || (op == `OP_QUAD_EXIT && quad);
      end
   endfunction
   // -------------------------------------------------------------
   // frame state machine
   // -------------------------------------------------------------
   reg [2:0]  st_r;
   reg [5:0]  bit_cnt_r;
   reg [23:0] addr_r;
   reg [7:0]  shin_r, shout_r;
   reg        out_en_r;
   reg        byte_edge_r;
   reg [15:0] busy_cnt_r;
   reg        opc_done_r;
   wire [2:0] step   = quad_mode_out ? 3'd4 : 3'd1;
   wire [7:0] shin_n = quad_mode_out ? {shin_r[3:0], sio_s2_r} : {shin_r[6:0], sio_s2_r[0]};
   wire [5:0] bits_n = bit_cnt_r + {3'd0, step};
   // -------------------------------------------------------------
   // two-entry request buffer
   // -------------------------------------------------------------
   reg [31:0] buf_mem [0:1];
   reg        wr_ptr_r, rd_ptr_r;
   reg [1:0]  cnt_r;
   reg        push;
   reg [31:0] push_word;
   // a write frame that ends while both entries are full is dropped as if
   // refused; the host is expected to poll busy before sending another
   wire       buf_ready = (cnt_r != 2'd2);
   wire       pop = (cnt_r != 2'd0) & (~op_valid_out | op_ready_in);
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         wr_ptr_r     <= 1'b0;
         rd_ptr_r     <= 1'b0;
         cnt_r        <= 2'd0;
         op_valid_out <= 1'b0;
         op_code_out  <= 8'h00;
         op_addr_out  <= 24'h0000_00;
         op_sector_out     <= 12'h000;
         op_half_block_out <= 9'h000;
         op_block_out      <= 8'h00;
      end else begin
         if (push & buf_ready) begin
            buf_mem[wr_ptr_r] <= push_word;
            wr_ptr_r          <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r          <= ~rd_ptr_r;
            op_valid_out      <= 1'b1;
            op_code_out       <= buf_mem[rd_ptr_r][31:24];
            op_addr_out       <= buf_mem[rd_ptr_r][23:0];
            op_sector_out     <= buf_mem[rd_ptr_r][`ADDR_W-1:`SECTOR_LSB];
            op_half_block_out <= buf_mem[rd_ptr_r][`ADDR_W-1:`HALF_BLOCK_LSB];
            op_block_out      <= buf_mem[rd_ptr_r][`ADDR_W-1:`BLOCK_LSB];
         end else if (op_ready_in) begin
            op_valid_out <= 1'b0;
         end
         cnt_r <= cnt_r + {1'b0, push & buf_ready} - {1'b0, pop};
      end
   end
   // -------------------------------------------------------------
   // main control
   // -------------------------------------------------------------
   always @* begin
      push      = 1'b0;
      push_word = {opc_r, addr_r};
      if (sel_rise && byte_edge_r && !busy_out && is_write_type(opc_r) && write_enable_latch_out &&
          (st_r == ST_WDATA || st_r == ST_OPC && opc_r == `OP_CHIP_ERASE ||
           st_r == ST_OPC && opc_r == `OP_CHIP_ERASE2 || st_r == ST_OPC && opc_r == `OP_STATUS_WR))
         push = 1'b1;
   end
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         st_r        <= ST_IDLE;
         bit_cnt_r   <= 6'd0;
         opc_r       <= 8'h00;
         addr_r      <= 24'h0000_00;
         shin_r      <= 8'h00;
         shout_r     <= 8'h00;
         out_en_r    <= 1'b0;
         byte_edge_r <= 1'b0;
         quad_mode_out          <= 1'b0;
         write_enable_latch_out <= 1'b0;
         opc_done_r  <= 1'b0;
         sio_out     <= 4'h0;
      end else begin
         // a request entering the buffer uses up the latch
         if (push & buf_ready)
            write_enable_latch_out <= 1'b0;
         if (sel_fall) begin
            st_r        <= ST_OPC;
            bit_cnt_r   <= 6'd0;
            byte_edge_r <= 1'b0;
            out_en_r    <= 1'b0;
            // a frame cut short must not act on the previous opcode
            opc_r       <= 8'h00;
            opc_done_r  <= 1'b0;
         end else if (sel_rise) begin
            // mode switches also require a whole byte
            if (st_r == ST_OPC && byte_edge_r && opc_r == `OP_QUAD_ENTER && !quad_mode_out)
               quad_mode_out <= 1'b1;
            if (st_r == ST_OPC && byte_edge_r && opc_r == `OP_QUAD_EXIT && quad_mode_out)
               quad_mode_out <= 1'b0;
            if (st_r == ST_OPC && byte_edge_r && opc_r == `OP_WRITE_EN && !busy_out)
               write_enable_latch_out <= 1'b1;
            if (st_r == ST_OPC && byte_edge_r && opc_r == `OP_WRITE_DIS && !busy_out)
               write_enable_latch_out <= 1'b0;
            st_r     <= ST_IDLE;
            out_en_r <= 1'b0;
         end else if (clk_rise) begin
            shin_r <= shin_n;
            byte_edge_r <= (bits_n[2:0] == 3'd0);
            bit_cnt_r   <= (bits_n == 6'd8) ? 6'd0 : bits_n;
            case (st_r)
               ST_OPC: begin
                  // only the first byte is an opcode; later bytes are data
                  if (bits_n == 6'd8 && !opc_done_r) begin
                     opc_done_r <= 1'b1;
                     opc_r      <= shin_n;
                     if (!is_known(shin_n, quad_mode_out))
                        st_r <= ST_STBY;
                     else if (busy_out && (needs_addr(shin_n) || is_write_type(shin_n)))
                        st_r <= ST_STBY;
                     else if (needs_addr(shin_n))
                        st_r <= ST_ADDR;
                     else if (shin_n == `OP_STATUS_RD) begin
                        st_r    <= ST_DATA;
                        shout_r <= {6'h00, write_enable_latch_out, busy_out};
                     end
                  end
               end
               ST_ADDR: begin
                  addr_r <= quad_mode_out ? {addr_r[19:0], sio_s2_r} : {addr_r[22:0], sio_s2_r[0]};
                  bit_cnt_r <= bits_n;
                  if (bits_n == 6'd24) begin
                     bit_cnt_r <= 6'd0;
                     if (opc_r == `OP_FAST_READ)
                        st_r <= ST_DUMMY;
                     else if (opc_r == `OP_READ) begin
                        st_r    <= ST_DATA;
                        shout_r <= rd_data_in;
                     end else
                        st_r <= ST_WDATA;
                  end
               end
               ST_DUMMY: begin
                  if (bits_n == `FAST_DUMMY_BITS) begin
                     st_r    <= ST_DATA;
                     shout_r <= rd_data_in;
                  end
               end
               ST_DATA: begin
                  // next byte is latched on the last rising edge
                  if (bits_n == 6'd8 && opc_r != `OP_STATUS_RD) begin
                     addr_r  <= addr_r + 24'h0000_01;
                     shout_r <= rd_data_in;
                  end else if (bits_n == 6'd8)
                     shout_r <= {6'h00, write_enable_latch_out, busy_out};
               end
               default: ;  // program data bytes are not stored by this front end
            endcase
         end else if (clk_fall && st_r == ST_DATA) begin
            out_en_r <= 1'b1;
            if (quad_mode_out) begin
               sio_out <= shout_r[7:4];
               shout_r <= {shout_r[3:0], 4'h0};
            end else begin
               sio_out <= {2'b00, shout_r[7], 1'b0};
               shout_r <= {shout_r[6:0], 1'b0};
            end
         end
      end
   end
   // -------------------------------------------------------------
   // internal operation timer
   // -------------------------------------------------------------
   // the length is a fixed count: the front end has no view of the
   // real array timing, so the array side must not finish later
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         busy_out   <= 1'b0;
         busy_cnt_r <= 16'h0000;
      end else if (push & buf_ready) begin
         busy_out   <= 1'b1;
         busy_cnt_r <= `BUSY_CYCLES;
      end else if (busy_out) begin
         if (busy_cnt_r == 16'h0001)
            busy_out <= 1'b0;
         busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
   end
   // -------------------------------------------------------------
   // data line enables
   // -------------------------------------------------------------
   // low while driving; released in idle and standby, and turned on one
   // clock after the first shift so the value settles before the lines turn
   always @(posedge ref_clk_in) begin
      if (srst_in)
         sio_oe_n_out <= 4'hF;
      else if (st_r == ST_DATA && out_en_r)
         sio_oe_n_out <= quad_mode_out ? 4'h0 : 4'hD;
      else
         sio_oe_n_out <= 4'hF;
   end
endmodule // flash_front_end

// File: flash_fe_consts.vh
`ifndef FLASH_FE_CONSTS_VH
`define FLASH_FE_CONSTS_VH
// opcodes
`define OP_READ          8'h03
`define OP_FAST_READ     8'h0B
`define OP_PAGE_PROG     8'h02
`define OP_SECTOR_ERASE  8'h20
`define OP_BLK32_ERASE   8'h52
`define OP_BLK64_ERASE   8'hD8
`define OP_CHIP_ERASE    8'h60
`define OP_CHIP_ERASE2   8'hC7
`define OP_WRITE_EN      8'h06
`define OP_WRITE_DIS     8'h04
`define OP_STATUS_RD     8'h05
`define OP_STATUS_WR     8'h01
`define OP_QUAD_ENTER    8'h35
`define OP_QUAD_EXIT     8'hF5
// array geometry: byte address field positions
`define ADDR_W           24
`define SECTOR_LSB       12
`define HALF_BLOCK_LSB   15
`define BLOCK_LSB        16
`define LAST_SECTOR_BASE 24'hFFF0_00
// internal operation length in ref clock cycles; fast read dummy length in bits
`define BUSY_CYCLES      16'h0040
`define FAST_DUMMY_BITS  6'h08
`endif

// File: fe_checker_assertions.sv
`timescale 1ns/1ps
module fe_checker (
   // watched ports
   input logic        ref_clk_in,
   input logic        srst_in,
   input logic        sel_n_in,
   input logic [3:0]  sio_oe_n_out,
   input logic        op_valid_out,
   input logic        op_ready_in,
   input logic [7:0]  op_code_out,
   input logic [23:0] op_addr_out,
   input logic [11:0] op_sector_out,
   input logic [8:0]  op_half_block_out,
   input logic [7:0]  op_block_out,
   input logic        quad_mode_out,
   input logic        write_enable_latch_out,
   input logic        busy_out
);
   logic [7:0] run_r;
   // length of the current busy run, read when busy drops
   always @(posedge ref_clk_in) run_r <= busy_out ? run_r + 8'h01 : 8'h00;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   a_idle_released: assert property (sel_n_in [*8] |-> sio_oe_n_out == 4'hF)
      else $error("data lines driven while deselected");
   a_req_hold: assert property (op_valid_out && !op_ready_in |=>
      op_valid_out && $stable(op_code_out) && $stable(op_addr_out))
      else $error("request changed while stalled");
   a_sector_map: assert property (op_valid_out |-> op_sector_out == op_addr_out[23:12])
      else $error("sector field wrong");
   a_half_map: assert property (op_valid_out |-> op_half_block_out == op_addr_out[23:15])
      else $error("half block field wrong");
   a_block_map: assert property (op_valid_out |-> op_block_out == op_addr_out[23:16])
      else $error("block field wrong");
   a_push_state: assert property ($rose(op_valid_out) |-> busy_out && !write_enable_latch_out)
      else $error("latch or busy wrong at request");
   a_busy_len: assert property ($fell(busy_out) |-> run_r == 8'h40)
      else $error("busy run length wrong");
   a_out_lines: assert property (sio_oe_n_out != 4'hF |->
      sio_oe_n_out == (quad_mode_out ? 4'h0 : 4'hD))
      else $error("wrong data lines enabled");
   c_push: cover property ($rose(op_valid_out));
   c_stall: cover property (op_valid_out && !op_ready_in);
   c_quad: cover property ($rose(quad_mode_out));
   c_busy_end: cover property ($fell(busy_out));
endmodule // fe_checker

bind flash_front_end fe_checker u_chk (.ref_clk_in, .srst_in, .sel_n_in, .sio_oe_n_out, .op_valid_out,
   .op_ready_in, .op_code_out, .op_addr_out, .op_sector_out, .op_half_block_out, .op_block_out,
   .quad_mode_out, .write_enable_latch_out, .busy_out);

// File: flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model #(parameter int GAP = 8) (
   // clock
   input  logic       ref_clk_in,
   // device pins
   input  logic [3:0] sio_out,
   input  logic [3:0] sio_oe_n_out,
   output logic       sel_n_out,
   output logic       sclk_out,
   output logic [3:0] sio_pin_out
);
   logic [3:0] drv_r = 4'h5;
   // undriven lines toggle so a stale value never looks valid
   assign sio_pin_out = (~sio_oe_n_out & sio_out) | (sio_oe_n_out & drv_r);
   initial sel_n_out = 1'b1;
   initial sclk_out = 1'b0;
   task automatic xfer(input logic [39:0] d, input int ntx, nrx, input logic q, m3, output logic [15:0] rx);
      rx = 16'h0000;
      sclk_out <= m3;
      @(posedge ref_clk_in);
      sel_n_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      for (int i = 0; i < ntx + nrx; i++) begin
         sclk_out <= 1'b0;
         if (i < ntx) drv_r <= q ? d[39-4*i -: 4] : {~drv_r[3:1], d[39-i]};
         else drv_r <= ~drv_r;
         repeat (4) @(posedge ref_clk_in);
         sclk_out <= 1'b1;
         repeat (3) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         if (i >= ntx) rx = q ? {rx[11:0], sio_pin_out} : {rx[14:0], sio_pin_out[1]};
         @(posedge ref_clk_in);
      end
      if (!m3) sclk_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      sel_n_out <= 1'b1;
      repeat (GAP) @(posedge ref_clk_in) drv_r <= ~drv_r;
   endtask
endmodule // flash_host_model

// File: tb.sv
`timescale 1ns/1ps
module tb;
   logic        ref_clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        op_ready_in = 1'b0;
   logic [7:0]  rd_data_in = 8'h00;
   logic        hold_r = 1'b1;
   logic        drove_r = 1'b0;
   logic [31:0] lf_r = 32'h293e_1fe8;
   wire         sel_n, sclk, op_valid, qm, write_enable_latch, busy;
   wire  [3:0]  sio, sio_o, oe_n;
   wire  [7:0]  code, blk;
   wire  [23:0] addr;
   wire  [11:0] sec;
   wire  [8:0]  hb;
   int          fail_count = 0;
   int          n_tests = 0;
   int          nreq = 0;
   int          len [7] = '{40, 32, 32, 32, 8, 8, 16};
   logic [7:0]  cmd [7] = '{8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h01};
   logic [31:0] req_q[$];
   logic [28:0] map_q[$];
   logic [23:0] a, ab [2];
   logic [15:0] rx;
   flash_front_end DUT (.ref_clk_in, .srst_in, .sel_n_in(sel_n), .sclk_in(sclk), .sio_in(sio), .sio_out(sio_o),
      .sio_oe_n_out(oe_n), .op_valid_out(op_valid), .op_ready_in, .op_code_out(code), .op_addr_out(addr),
      .op_sector_out(sec), .op_half_block_out(hb), .op_block_out(blk), .rd_data_in, .quad_mode_out(qm),
      .write_enable_latch_out(write_enable_latch), .busy_out(busy), .quad_enable_bit_in(lf_r[5]));
   flash_host_model host (.ref_clk_in, .sio_out(sio_o), .sio_oe_n_out(oe_n), .sel_n_out(sel_n),
      .sclk_out(sclk), .sio_pin_out(sio));
   initial forever #50 ref_clk_in = ~ref_clk_in;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // random stalls, request capture, output watch
   always @(posedge ref_clk_in) begin
      lf_r <= lfsr(lf_r);
      op_ready_in <= !hold_r & lf_r[2];
      if (op_valid === 1'b1 && op_ready_in) req_q.push_back({code, addr});
      if (op_valid === 1'b1 && op_ready_in) map_q.push_back({sec, hb, blk});
      if (oe_n !== 4'hF) drove_r <= 1'b1;
   end
   task chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task x(input logic [39:0] d, input int ntx, nrx, input logic q);
      host.xfer(d, ntx, nrx, q, lf_r[3], rx);
   endtask
   task wreq(input int n);
      repeat (400) if (req_q.size() < n) @(posedge ref_clk_in);
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk_in);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      @(negedge ref_clk_in);
      chk("oe_n", 4'hF, oe_n);
      hold_r = 1'b0;
      repeat (3) @(posedge ref_clk_in);
      for (int m = 0; m < 2; m++) begin
         host.xfer({8'h05, 32'h0}, 8, 8, 1'b0, m[0], rx);
         chk("status", 8'h00, rx[7:0]);
      end
      $display("test reset_status done");
      for (int k = 0; k < 7; k++) begin
         a = (k == 1) ? 24'hFFF0_00 : lf_r[23:0];
         x({8'h06, 32'h0}, 8, 0, 0);
         x({8'h05, 32'h0}, 8, 8, 0);
         chk("wel", 8'h02, rx[7:0]);
         chk("wel_pin", 1, write_enable_latch);
         x({cmd[k], a, 8'h00}, len[k], 0, 0);
         nreq++;
         wreq(nreq);
         chk("busy_pin", 1, busy);
         chk("code", cmd[k], req_q[nreq-1][31:24]);
         if (k < 4) chk("addr", a, req_q[nreq-1][23:0]);
         if (k < 4) chk("map", {a[23:12], a[23:15], a[23:16]}, map_q[nreq-1]);
      end
      $display("test write_types done");
      x({8'h06, 32'h0}, 7, 0, 0);
      x({8'h20, lf_r[23:0], 8'h00}, 32, 0, 0);
      x({8'h06, 32'h0}, 8, 0, 0);
      x({8'h20, lf_r[23:0], 8'h00}, 31, 0, 0);
      repeat (20) @(posedge ref_clk_in);
      chk("dropped", nreq, req_q.size());
      drove_r = 1'b0;
      x({8'hFF, 8'h05, 24'h0}, 16, 8, 0);
      chk("standby", 0, drove_r);
      $display("test refusals done");
      rd_data_in <= lf_r[7:0];
      x({8'h03, lf_r[23:0], 8'h00}, 32, 16, 0);
      chk("read", {2{rd_data_in}}, rx);
      x({8'h0B, lf_r[23:0], 8'h00}, 40, 3, 0);
      chk("read_cut", rd_data_in[7:5], rx[2:0]);
      $display("test reads done");
      hold_r <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         ab[k] = lf_r[23:0];
         x({8'h06, 32'h0}, 8, 0, 0);
         x({8'hD8, ab[k], 8'h00}, 32, 0, 0);
      end
      hold_r <= 1'b0;
      nreq += 2;
      wreq(nreq);
      chk("first", {8'hD8, ab[0]}, req_q[nreq-2]);
      chk("second", {8'hD8, ab[1]}, req_q[nreq-1]);
      $display("test buffer done");
      x({8'h35, 32'h0}, 8, 0, 0);
      chk("quad", 1, qm);
      x({8'h05, 32'h0}, 2, 2, 1);
      chk("qstatus", 8'h00, rx[7:0]);
      x({8'h06, 32'h0}, 2, 0, 1);
      a = lf_r[23:0];
      x({8'h20, a, 8'h00}, 8, 0, 1);
      nreq++;
      drove_r = 1'b0;
      x({8'h03, a, 8'h00}, 8, 4, 1);
      chk("busy_read", 0, drove_r);
      wreq(nreq);
      chk("qerase", {8'h20, a}, req_q[nreq-1]);
      x({8'hF5, 32'h0}, 2, 0, 1);
      chk("single", 0, qm);
      $display("test quad done");
      give_verdict();
   end
endmodule // tb
